//--- shared/bml_pkg.sv
// Constants and types for the boot-time mode serial loader
package bml_pkg;
  // ==========================================================
  // Serial clock and stream
  localparam int SCLK_DIV = 256;
  localparam int SCLK_HALF = SCLK_DIV / 2;
  localparam logic [6:0] HALF_LAST = 7'(SCLK_HALF - 1);
  localparam int STREAM_BITS = 256;
  localparam logic [8:0] STREAM_LEN = 9'(STREAM_BITS);
  // ==========================================================
  // Mode bit positions
  localparam int ZERO_LO = 15;
  localparam int DRV_HI = 14;
  localparam int DRV_LO = 13;
  localparam int WIDTH_BIT = 12;
  localparam int TMR_BIT = 11;
  localparam int PROTO_HI = 10;
  localparam int PROTO_LO = 9;
  localparam int ENDIAN_BIT = 8;
  localparam int MULT_HI = 7;
  localparam int MULT_LO = 5;
  localparam int WB_HI = 4;
  localparam int WB_LO = 1;
  localparam int RSVD_BIT = 0;
  localparam logic [3:0] MULT_BASE = 4'h2;
  localparam logic [2:0] MULT_RSVD = 3'h7;
  localparam logic [3:0] WB_MAX = 4'h8;
  // Drive strength in percent
  localparam logic [6:0] PCT_100 = 7'h64;
  localparam logic [6:0] PCT_83 = 7'h53;
  localparam logic [6:0] PCT_67 = 7'h43;
  localparam logic [6:0] PCT_50 = 7'h32;
  // ==========================================================
  // Register map (byte addresses)
  localparam int ADDR_W = 6;
  localparam logic [5:0] OFF_CTRL = 6'h00;
  localparam logic [5:0] OFF_STATUS = 6'h04;
  localparam logic [5:0] OFF_CFG = 6'h08;
  localparam int CAP_SEL_BIT = 5;
  localparam logic CTRL_EN_RST = 1'b1;
  // ==========================================================
  // Types
  typedef enum logic [1:0] {
    BML_IDLE = 2'b00,
    BML_LOAD = 2'b01,
    BML_DONE = 2'b10
  } bml_state_e;
  typedef enum logic [1:0] {
    BML_COMPAT = 2'b00,
    BML_PRSVD = 2'b01,
    BML_PIPE = 2'b10,
    BML_REISSUE = 2'b11
  } bml_proto_e;
endpackage

//--- rtl/bml_boot_loader.sv
// Boot-time mode serial loader with mode decode and write issue
// Notes on behaviour
// - Serial clock is the system clock divided by 256; bits sampled there.
// - After power good rises, exactly 256 serial mode bits are read.
// - After the load the serial clock keeps toggling; data is ignored.
// - Bits 14:13 pick drive: 10=100, 11=83, 00=67, 01=50 percent.
// - Bit 11 set suppresses the timer interrupt on line five.
// - Bit 12 picks interface width: 0 is 64-bit, 1 is 32-bit.
// - Bits 10:9 pick write protocol: compat, reserved, pipelined, reissue.
// - Bit 8 picks byte order: 0 little endian, 1 big endian.
// - Bits 7:5 give clock multiplier value plus two; 7 is reserved.
// - Bits 4:1 pick writeback pattern; values 9 to 15 are reserved.
// - Compat issues on ready now; pipelined/reissue need ready two cycles ago and now; else reissue/extra.
// - Core clock multiplier comes from the factor captured at boot.
//
// Added by the designer: the Avalon-MM interface to the registers and the register addresses.
module bml_boot_loader (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic power_good,
  input wire logic mode_sdata,
  output logic mode_sclk,
  input wire logic timer_irq,
  input wire logic write_accept_ready_n,
  input wire logic wr_pending,
  output logic wr_issue,
  output logic wr_reissue,
  output logic load_done,
  output logic [6:0] drive_pct,
  output logic width32,
  output logic big_endian,
  output logic [1:0] wr_proto,
  output logic [3:0] clk_mult,
  output logic [3:0] wb_pattern,
  output logic cfg_error,
  output logic timer_int5,
  input wire logic [bml_pkg::ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest
);
  import bml_pkg::*;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  function automatic logic [6:0] bml_drive_pct(input logic [1:0] code);
    case (code)
      2'b10: bml_drive_pct = PCT_100;
      2'b11: bml_drive_pct = PCT_83;
      2'b00: bml_drive_pct = PCT_67;
      default: bml_drive_pct = PCT_50;
    endcase
  endfunction

  // ==========================================================
  // Input synchronisers
  logic [1:0] pg_sync_reg;
  logic [1:0] sd_sync_reg;
  logic [1:0] rdy_sync_reg;
  logic pg_s;
  logic sd_s;
  logic ready_s;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pg_sync_reg <= 2'h0;
      sd_sync_reg <= 2'h0;
      rdy_sync_reg <= 2'h3;
    end else begin
      pg_sync_reg <= {pg_sync_reg[0], power_good};
      sd_sync_reg <= {sd_sync_reg[0], mode_sdata};
      rdy_sync_reg <= {rdy_sync_reg[0], write_accept_ready_n};
    end
  end
  assign pg_s = pg_sync_reg[1];
  assign sd_s = sd_sync_reg[1];
  assign ready_s = !rdy_sync_reg[1];

  // ==========================================================
  // Serial clock divider, free running so the pin never stops
  logic [6:0] half_reg;
  logic sclk_reg;
  logic sclk_rise;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      half_reg <= 7'h00;
      sclk_reg <= 1'b0;
    end else if (half_reg == HALF_LAST) begin
      half_reg <= 7'h00;
      sclk_reg <= !sclk_reg;
    end else begin
      half_reg <= half_reg + 7'h01;
    end
  end
  assign sclk_rise = (half_reg == HALF_LAST) && !sclk_reg;
  assign mode_sclk = sclk_reg;

  a_sclk_toggle: assert property (
    (half_reg == HALF_LAST) |=> (sclk_reg != $past(sclk_reg))
  ) else $error("serial clock missed its toggle");
  a_sclk_steady: assert property (
    (half_reg != HALF_LAST) |=> $stable(sclk_reg)
  ) else $error("serial clock toggled early");

  // ==========================================================
  // Load sequencer and capture register
  bml_state_e state_reg;
  bml_state_e state_next;
  logic [8:0] bit_cnt_reg;
  logic [255:0] cap_reg;

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      BML_IDLE: begin
        if (pg_s) begin
          state_next = BML_LOAD;
        end
      end
      BML_LOAD: begin
        if (sclk_rise && bit_cnt_reg == STREAM_LEN - 9'h001) begin
          state_next = BML_DONE;
        end
      end
      BML_DONE: state_next = BML_DONE;
      default: state_next = BML_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= BML_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // Bit 0 arrives first, so shifting in at the top lands it at index 0
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cap_reg <= '0;
      bit_cnt_reg <= 9'h000;
    end else if (state_reg == BML_LOAD && sclk_rise) begin
      cap_reg <= {sd_s, cap_reg[255:1]};
      bit_cnt_reg <= bit_cnt_reg + 9'h001;
    end
  end

  a_count_limit: assert property (
    bit_cnt_reg <= STREAM_LEN
  ) else $error("more than 256 mode bits taken");
  a_no_capture: assert property (
    (state_reg == BML_DONE) |=> $stable(cap_reg) && $stable(bit_cnt_reg)
  ) else $error("mode bits captured after load");

  // ==========================================================
  // Decoded settings, frozen once loaded
  logic load_done_reg;
  logic [6:0] drive_pct_reg;
  logic width32_reg;
  logic tmr_dis_reg;
  logic big_endian_reg;
  bml_proto_e proto_reg;
  logic [3:0] clk_mult_reg;
  logic [3:0] wb_pattern_reg;
  logic cfg_error_reg;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      load_done_reg <= 1'b0;
      drive_pct_reg <= 7'h00;
      width32_reg <= 1'b0;
      tmr_dis_reg <= 1'b0;
      big_endian_reg <= 1'b0;
      proto_reg <= BML_COMPAT;
      clk_mult_reg <= 4'h0;
      wb_pattern_reg <= 4'h0;
      cfg_error_reg <= 1'b0;
    end else if (state_reg == BML_DONE && !load_done_reg) begin
      load_done_reg <= 1'b1;
      drive_pct_reg <= bml_drive_pct(cap_reg[DRV_HI:DRV_LO]);
      width32_reg <= cap_reg[WIDTH_BIT];
      tmr_dis_reg <= cap_reg[TMR_BIT];
      big_endian_reg <= cap_reg[ENDIAN_BIT];
      proto_reg <= bml_proto_e'(cap_reg[PROTO_HI:PROTO_LO]);
      clk_mult_reg <= {1'b0, cap_reg[MULT_HI:MULT_LO]} + MULT_BASE;
      wb_pattern_reg <= cap_reg[WB_HI:WB_LO];
      // Reserved codes are still applied; software sees the flag
      cfg_error_reg <= (|cap_reg[255:ZERO_LO]) | cap_reg[RSVD_BIT]
        | (cap_reg[PROTO_HI:PROTO_LO] == BML_PRSVD)
        | (cap_reg[MULT_HI:MULT_LO] == MULT_RSVD)
        | (cap_reg[WB_HI:WB_LO] > WB_MAX);
    end
  end

  assign load_done = load_done_reg;
  assign drive_pct = drive_pct_reg;
  assign width32 = width32_reg;
  assign big_endian = big_endian_reg;
  assign wr_proto = proto_reg;
  assign clk_mult = clk_mult_reg;
  assign wb_pattern = wb_pattern_reg;
  assign cfg_error = cfg_error_reg;

  a_done_count: assert property (
    load_done_reg |-> (bit_cnt_reg == STREAM_LEN)
  ) else $error("load done before 256 bits");
  a_drive_map: assert property (
    load_done_reg |-> drive_pct_reg == (cap_reg[DRV_HI]
      ? (cap_reg[DRV_LO] ? PCT_83 : PCT_100)
      : (cap_reg[DRV_LO] ? PCT_50 : PCT_67))
  ) else $error("drive strength does not match mode bits");
  a_mult_map: assert property (
    load_done_reg |->
      clk_mult_reg == {1'b0, cap_reg[MULT_HI:MULT_LO]} + MULT_BASE
  ) else $error("clock multiplier does not match mode bits");
  a_width_map: assert property (
    load_done_reg |-> width32_reg == cap_reg[WIDTH_BIT]
  ) else $error("interface width does not match mode bit");

  // ==========================================================
  // Timer interrupt gate
  logic timer_int5_reg;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      timer_int5_reg <= 1'b0;
    end else begin
      timer_int5_reg <= load_done_reg && !tmr_dis_reg && timer_irq;
    end
  end
  assign timer_int5 = timer_int5_reg;

  a_timer_gate: assert property (
    timer_int5_reg |-> $past(timer_irq) && !$past(tmr_dis_reg)
  ) else $error("timer interrupt passed while disabled");

  // ==========================================================
  // Write issue engine
  logic ctrl_en_reg;
  logic [1:0] rdy_hist_reg;
  logic gap_reg;
  logic extra_reg;
  logic wr_issue_reg;
  logic wr_reissue_reg;
  logic eng_on;
  logic issue_ok;
  logic go;
  logic reissue_c;

  assign eng_on = load_done_reg && ctrl_en_reg && wr_pending && !gap_reg;
  always_comb begin
    case (proto_reg)
      BML_COMPAT: issue_ok = ready_s;
      BML_PIPE: issue_ok = (ready_s && rdy_hist_reg[1])
        || (extra_reg && !ready_s);
      BML_REISSUE: issue_ok = ready_s && rdy_hist_reg[1];
      default: issue_ok = 1'b0;
    endcase
  end
  assign go = eng_on && issue_ok;
  assign reissue_c = eng_on && proto_reg == BML_REISSUE
    && rdy_hist_reg[1] && !ready_s;

  // Gap keeps the two-cycle repeat rate
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rdy_hist_reg <= 2'h0;
      gap_reg <= 1'b0;
      extra_reg <= 1'b0;
      wr_issue_reg <= 1'b0;
      wr_reissue_reg <= 1'b0;
    end else begin
      rdy_hist_reg <= {rdy_hist_reg[0], ready_s};
      gap_reg <= go || reissue_c;
      if (go) begin
        extra_reg <= (proto_reg == BML_PIPE) && ready_s;
      end
      wr_issue_reg <= go;
      wr_reissue_reg <= reissue_c;
    end
  end
  assign wr_issue = wr_issue_reg;
  assign wr_reissue = wr_reissue_reg;

  a_issue_rate: assert property (
    (wr_issue_reg || wr_reissue_reg) |=> !wr_issue_reg && !wr_reissue_reg
  ) else $error("writes closer than two cycles");
  a_reissue_ready: assert property (
    (wr_issue_reg && proto_reg == BML_REISSUE)
      |-> $past(ready_s, 1) && $past(ready_s, 3)
  ) else $error("reissue write without ready two cycles apart");
  a_engine_idle: assert property (
    !load_done_reg |=> !wr_issue_reg && !wr_reissue_reg
  ) else $error("write issued before mode load");

  // ==========================================================
  // Avalon-MM slave, one wait state per access
  logic wait_reg;
  logic [31:0] rdata_reg;
  logic [31:0] rd_word;

  always_comb begin
    rd_word = 32'h0000_0000;
    if (avs_address[CAP_SEL_BIT]) begin
      rd_word = cap_reg[{avs_address[4:2], 5'h00} +: 32];
    end else if (avs_address == OFF_CTRL) begin
      rd_word = {31'h0000_0000, ctrl_en_reg};
    end else if (avs_address == OFF_STATUS) begin
      rd_word = {7'h00, bit_cnt_reg, 12'h000, state_reg, cfg_error_reg,
                 load_done_reg};
    end else if (avs_address == OFF_CFG) begin
      rd_word = {drive_pct_reg, 9'h000, clk_mult_reg, wb_pattern_reg,
                 proto_reg, tmr_dis_reg, big_endian_reg, width32_reg, 3'h0};
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      wait_reg <= 1'b1;
      rdata_reg <= 32'h0000_0000;
    end else begin
      wait_reg <= !((avs_read || avs_write) && wait_reg);
      if (avs_read && wait_reg) begin
        rdata_reg <= rd_word;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_en_reg <= CTRL_EN_RST;
    end else if (avs_write && !wait_reg && avs_address == OFF_CTRL
                 && avs_byteenable[0]) begin
      ctrl_en_reg <= avs_writedata[0];
    end
  end
  assign avs_readdata = rdata_reg;
  assign avs_waitrequest = wait_reg;

  a_bus_answer: assert property (
    ((avs_read || avs_write) && wait_reg) |=> !wait_reg ##1 wait_reg
  ) else $error("bus access not answered in one cycle");

endmodule // bml_boot_loader

//--- bench/bml_rom_model.sv
// Serial mode source model for the boot loader bench
module bml_rom_model (
  input wire logic clk_sys,
  input wire logic power_good,
  input wire logic mode_sclk,
  input wire logic [255:0] image,
  output logic mode_sdata
);
  timeunit 1ns;
  timeprecision 1ns;
  // ==========================================================
  // Stream source
  logic [8:0] idx_reg = 9'h000;
  logic tog_reg = 1'b0;
  // Bit 0 stands while power good rises, then one bit per rise
  always @(posedge mode_sclk) begin
    if (power_good && idx_reg != 9'h100) begin
      idx_reg <= idx_reg + 9'h001;
    end
  end
  // Past the stream the line toggles, so stale bits cannot pass
  always @(posedge clk_sys) begin
    tog_reg <= ~tog_reg;
  end
  assign mode_sdata = idx_reg[8] ? tog_reg : image[idx_reg[7:0]];
endmodule // bml_rom_model

//--- bench/tb_top.sv
// Self-checking bench for the boot-time mode serial loader
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import bml_pkg::*;
  // ==========================================================
  // Signals
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic power_good = 1'b0;
  logic timer_irq = 1'b0;
  logic write_accept_ready_n = 1'b1;
  logic wr_pending = 1'b0;
  logic [5:0] avs_address = 6'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0] avs_byteenable = 4'hF;
  logic mode_sdata, mode_sclk, wr_issue, wr_reissue, load_done;
  logic width32, big_endian, cfg_error, timer_int5, avs_waitrequest;
  logic [6:0] drive_pct;
  logic [1:0] wr_proto;
  logic [3:0] clk_mult, wb_pattern;
  logic [31:0] avs_readdata;
  logic [255:0] image = '0;
  integer seed = 32'h4dd7;
  int n_mismatch = 0;
  int compares = 0;
  initial forever #20 clk_sys = ~clk_sys;
  bml_boot_loader i_dut (.clk_sys(clk_sys), .rst_n(rst_n),
    .power_good(power_good), .mode_sdata(mode_sdata),
    .mode_sclk(mode_sclk), .timer_irq(timer_irq),
    .write_accept_ready_n(write_accept_ready_n), .wr_pending(wr_pending),
    .wr_issue(wr_issue), .wr_reissue(wr_reissue), .load_done(load_done),
    .drive_pct(drive_pct), .width32(width32), .big_endian(big_endian),
    .wr_proto(wr_proto), .clk_mult(clk_mult), .wb_pattern(wb_pattern),
    .cfg_error(cfg_error), .timer_int5(timer_int5),
    .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest));
  bml_rom_model i_rom (.clk_sys(clk_sys), .power_good(power_good),
    .mode_sclk(mode_sclk), .image(image), .mode_sdata(mode_sdata));
  // ==========================================================
  // Expectations
  function automatic logic [6:0] exp_drv(input logic [1:0] c);
    case (c)
      2'b10: return PCT_100;
      2'b11: return PCT_83;
      2'b00: return PCT_67;
      default: return PCT_50;
    endcase
  endfunction
  function automatic logic exp_err(input logic [255:0] m);
    return m[9:8] == 2'b01 || m[7:5] == 3'h7 || m[4:1] > 4'h8;
  endfunction
  function automatic logic [31:0] exp_cfg(input logic [255:0] m);
    return {exp_drv(m[14:13]), 9'h0, {1'b0, m[7:5]} + 4'h2, m[4:1],
      m[10:9], m[11], m[8], m[12], 3'h0};
  endfunction
  // ==========================================================
  // Tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
    input string what);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  // Request held until waitrequest is sampled low at a rising edge
  task automatic bus(input logic wr, input logic [5:0] a,
    input logic [31:0] wd, input logic [3:0] be, output logic [31:0] rd);
    int n = 0;
    @(posedge clk_sys);
    avs_address <= a;
    avs_writedata <= wd;
    avs_byteenable <= be;
    avs_write <= wr;
    avs_read <= ~wr;
    @(posedge clk_sys);
    while (avs_waitrequest !== 1'b0) begin
      n++;
      @(posedge clk_sys);
    end
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    chk(32'(n), 32'h1, "bus wait");
  endtask
  task automatic rdchk(input logic [5:0] a, input logic [31:0] e,
    input string w);
    logic [31:0] d;
    bus(1'b0, a, 32'h0, 4'hF, d);
    chk(d, e, w);
  endtask
  task automatic sclk_period();
    time t0;
    @(posedge mode_sclk);
    t0 = $time;
    @(negedge mode_sclk);
    chk(32'($time - t0), 32'(SCLK_HALF * 40), "sclk high");
    @(posedge mode_sclk);
    chk(32'($time - t0), 32'(SCLK_DIV * 40), "sclk period");
  endtask
  // Counts write pulses; adj counts pulses in neighbouring cycles
  task automatic watch(input int cyc, output int iss, output int re,
    output int adj);
    logic prev = 1'b0;
    iss = 0;
    re = 0;
    adj = 0;
    repeat (cyc) begin
      @(negedge clk_sys);
      iss += int'(wr_issue === 1'b1);
      re += int'(wr_reissue === 1'b1);
      adj += int'(prev && (wr_issue || wr_reissue));
      prev = wr_issue | wr_reissue;
    end
  endtask
  task automatic complete_run();
    $display("Counts: %0d compares, %0d mismatches", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // ==========================================================
  // Watchdog, sized above one full load plus the checks
  initial begin
    #(85000 * 40);
    n_mismatch++;
    complete_run();
  end
  // ==========================================================
  // Main sequence
  initial begin
    logic [31:0] d;
    int rises, since, early, iss, re, adj;
    logic prev;
    image[14:1] = 14'($random(seed));
    image[10:9] = 2'b11;
    repeat (8) @(posedge clk_sys);
    rst_n <= 1'b1;
    sclk_period();
    rdchk(OFF_CTRL, 32'h1, "ctrl reset");
    rdchk(OFF_STATUS, 32'h0, "status idle");
    bus(1'b1, 6'h10, 32'hFFFF_FFFF, 4'hF, d);
    rdchk(6'h10, 32'h0, "unmapped");
    $display("test bus done");
    wr_pending <= 1'b1;
    write_accept_ready_n <= 1'b0;
    timer_irq <= 1'b1;
    @(negedge mode_sclk);
    power_good <= 1'b1;
    rises = 0;
    since = 0;
    early = 0;
    prev = 1'b0;
    // Bounded wait for completion; sample rises and idle outputs
    for (int n = 0; n < 70000 && load_done !== 1'b1; n++) begin
      @(negedge clk_sys);
      since++;
      if (mode_sclk === 1'b1 && !prev) begin
        rises++;
        since = 0;
      end
      prev = mode_sclk;
      if (load_done !== 1'b1) begin
        early += int'(wr_issue !== 1'b0 || timer_int5 !== 1'b0);
        early += int'(drive_pct !== 7'h0 || clk_mult !== 4'h0);
      end
    end
    chk(32'(rises), 32'(STREAM_BITS), "bit count");
    chk(32'(since), 32'h1, "done delay");
    chk(32'(early), 32'h0, "early activity");
    chk(32'(drive_pct), 32'(exp_drv(image[14:13])), "drive");
    chk(32'(width32), 32'(image[12]), "width");
    chk(32'(wr_proto), 32'(image[10:9]), "proto");
    chk(32'(big_endian), 32'(image[8]), "endian");
    chk(32'(clk_mult), 32'(image[7:5]) + 32'h2, "mult");
    chk(32'(wb_pattern), 32'(image[4:1]), "wb");
    chk(32'(cfg_error), 32'(exp_err(image)), "cfg err");
    $display("test load done");
    sclk_period();
    repeat (600) @(posedge clk_sys);
    rdchk(OFF_STATUS, {7'h0, STREAM_LEN, 12'h0, 2'b10, exp_err(image),
      1'b1}, "status done");
    rdchk(OFF_CFG, exp_cfg(image), "cfg word");
    for (int k = 0; k < 8; k++) begin
      rdchk(6'h20 + 6'(4 * k), image[32 * k +: 32], "capture");
    end
    @(negedge clk_sys);
    chk(32'(timer_int5), 32'(!image[11]), "timer on");
    @(posedge clk_sys);
    timer_irq <= 1'b0;
    @(negedge clk_sys);
    chk(32'(timer_int5), 32'(!image[11]), "timer delay");
    @(negedge clk_sys);
    chk(32'(timer_int5), 32'h0, "timer off");
    $display("test decode done");
    watch(40, iss, re, adj);
    chk(32'(iss > 0), 32'h1, "issue ready");
    chk(32'(re + adj), 32'h0, "no repeat");
    @(posedge clk_sys);
    write_accept_ready_n <= 1'b1;
    watch(20, iss, re, adj);
    chk(32'(re > 0), 32'h1, "reissue");
    chk(32'(adj), 32'h0, "spacing");
    bus(1'b1, OFF_CTRL, 32'h0, 4'h0, d);
    rdchk(OFF_CTRL, 32'h1, "ctrl lane off");
    bus(1'b1, OFF_CTRL, 32'h0, 4'h1, d);
    rdchk(OFF_CTRL, 32'h0, "ctrl off");
    write_accept_ready_n <= 1'b0;
    watch(20, iss, re, adj);
    chk(32'(iss + re), 32'h0, "engine off");
    $display("test write done");
    complete_run();
  end
endmodule // tb_top
